// ---- logic/pcs_clock_select.sv ----
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module pcs_clock_select (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [`PCS_ADDR_W-1:0] addr_i,
  input wire logic [`PCS_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`PCS_DATA_W-1:0] rdata_o,
  input wire logic fll_output_clock_i,
  input wire logic pll_output_clock_i,
  input wire logic oscillator_reference_clock_i,
  input wire logic internal_reference_clock_i,
  input wire logic usb_bypass_clock_pin_i,
  input wire logic bus_clock_i,
  input wire logic low_power_oscillator_i,
  input wire logic rtc_tick_i,
  input wire logic timer_ext_clock_pin_a_i,
  input wire logic timer_ext_clock_pin_b_i,
  input wire logic analog_comparator_zero_i,
  input wire logic timer2_channel0_pin_i,
  input wire logic timer1_channel0_pin_i,
  output logic serial0_clock_o,
  output logic timer_counter_clock_o,
  output logic usb_clock_o,
  output logic general_clock_output_pin_o,
  output logic rtc_clock_output_pin_o,
  output logic timer0_ext_clock_o,
  output logic timer1_ext_clock_o,
  output logic timer2_ext_clock_o,
  output logic timer1_capture_o,
  output logic timer2_capture_o
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Four-way source pick shared by the serial and timer selectors.
  function automatic logic pcs_pick4(input logic [1:0] sel, input logic hs,
                                     input logic osc, input logic irc);
    logic res;
    res = 1'b0;
    case (pcs_pkg::pcs_src_t'(sel))
      pcs_pkg::PCS_SRC_OFF: res = 1'b0;
      pcs_pkg::PCS_SRC_HS: res = hs;
      pcs_pkg::PCS_SRC_OSC: res = osc;
      pcs_pkg::PCS_SRC_IRC: res = irc;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  // Address decode used by both the write and the read path.
  function automatic logic pcs_hit(input logic [`PCS_ADDR_W-1:0] a,
                                   input logic [`PCS_ADDR_W-1:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------

  // All source clocks and pins are foreign to mclk_i and are sampled here.
  logic [`PCS_NSYNC-1:0] raw_in;
  logic [`PCS_NSYNC-1:0] syn;

  assign raw_in = {timer1_channel0_pin_i, timer2_channel0_pin_i,
                   analog_comparator_zero_i, timer_ext_clock_pin_b_i,
                   timer_ext_clock_pin_a_i, rtc_tick_i, low_power_oscillator_i,
                   bus_clock_i, usb_bypass_clock_pin_i,
                   internal_reference_clock_i, oscillator_reference_clock_i,
                   pll_output_clock_i, fll_output_clock_i};

  // Two flip-flops stand between every pin and the logic below.
  pcs_sync2 #(
    .W(`PCS_NSYNC)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i(raw_in),
    .sync_o(syn)
  );

  // ----------------------------------------------------------------------
  // Option registers
  // ----------------------------------------------------------------------

  // Clock source options, only writable bits are ever stored.
  logic [`PCS_DATA_W-1:0] cso_q;
  // Timer source options, only writable bits are ever stored.
  logic [`PCS_DATA_W-1:0] tso_q;

  // Writes are masked so reserved bits can never become one.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cso_q <= `PCS_CSO_RST;
    end else if (wr_i && pcs_hit(addr_i, `PCS_CSO_OFF)) begin
      cso_q <= wdata_i & `PCS_CSO_MASK;
    end
  end

  // Same policy for the timer options register.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tso_q <= `PCS_TSO_RST;
    end else if (wr_i && pcs_hit(addr_i, `PCS_TSO_OFF)) begin
      tso_q <= wdata_i & `PCS_TSO_MASK;
    end
  end

  // Read data stand one cycle after the strobe and only then.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      if (pcs_hit(addr_i, `PCS_CSO_OFF)) begin
        rdata_o <= cso_q & `PCS_CSO_MASK;
      end else if (pcs_hit(addr_i, `PCS_TSO_OFF)) begin
        rdata_o <= tso_q & `PCS_TSO_MASK;
      end else begin
        // Unmapped addresses answer with zero.
        rdata_o <= '0;
      end
    end else begin
      rdata_o <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------------

  // Named slices of the stored option bits.
  logic [1:0] serial0_clock_source;
  logic [1:0] timer_counter_clock_source;
  logic usb_clock_source;
  logic highspeed_clock_pick;
  logic [2:0] clock_output_select;
  logic rtc_output_select;
  logic timer2_ext_clock_pin;
  logic timer1_ext_clock_pin;
  logic timer0_ext_clock_pin;
  logic timer2_capture_source;
  logic timer1_capture_source;

  assign serial0_clock_source = cso_q[`PCS_SER0_HI:`PCS_SER0_LO];
  assign timer_counter_clock_source = cso_q[`PCS_TMR_HI:`PCS_TMR_LO];
  assign usb_clock_source = cso_q[`PCS_USB_BIT];
  assign highspeed_clock_pick = cso_q[`PCS_HS_BIT];
  assign clock_output_select = cso_q[`PCS_GENERAL_CLOCK_OUTPUT_PIN_HI:`PCS_GENERAL_CLOCK_OUTPUT_PIN_LO];
  assign rtc_output_select = cso_q[`PCS_RTC_BIT];
  assign timer2_ext_clock_pin = tso_q[`PCS_T2PIN_BIT];
  assign timer1_ext_clock_pin = tso_q[`PCS_T1PIN_BIT];
  assign timer0_ext_clock_pin = tso_q[`PCS_T0PIN_BIT];
  assign timer2_capture_source = tso_q[`PCS_T2CAP_BIT];
  assign timer1_capture_source = tso_q[`PCS_T1CAP_BIT];

  // ----------------------------------------------------------------------
  // Halved PLL clock and high-speed pick
  // ----------------------------------------------------------------------

  // Previous synchronised PLL level, for rising-edge detection.
  logic pll_prev_q;
  // Divide-by-two of the sampled PLL clock.
  logic pll_half_q;
  // Shared high-speed source feeding serial, timer and USB.
  logic hs_clk;

  // Toggle on each sampled PLL rising edge for a fixed divide by two.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pll_prev_q <= 1'b0;
      pll_half_q <= 1'b0;
    end else begin
      pll_prev_q <= syn[`PCS_IN_PLL];
      if (syn[`PCS_IN_PLL] && !pll_prev_q) begin
        pll_half_q <= !pll_half_q;
      end
    end
  end

  // Zero routes the FLL, one routes the halved PLL.
  assign hs_clk = highspeed_clock_pick ? pll_half_q : syn[`PCS_IN_FLL];

  // ----------------------------------------------------------------------
  // Clock source multiplexers
  // ----------------------------------------------------------------------

  // Peripheral clocks; each output is a flop so it cannot glitch combinationally.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      serial0_clock_o <= 1'b0;
      timer_counter_clock_o <= 1'b0;
      usb_clock_o <= 1'b0;
    end else begin
      serial0_clock_o <= pcs_pick4(serial0_clock_source, hs_clk,
                                   syn[`PCS_IN_OSC], syn[`PCS_IN_IRC]);
      timer_counter_clock_o <= pcs_pick4(timer_counter_clock_source, hs_clk,
                                         syn[`PCS_IN_OSC], syn[`PCS_IN_IRC]);
      usb_clock_o <= usb_clock_source ? hs_clk : syn[`PCS_IN_USB];
    end
  end

  // Pin clock outputs; reserved output codes drive a steady low.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      general_clock_output_pin_o <= 1'b0;
      rtc_clock_output_pin_o <= 1'b0;
    end else begin
      case (clock_output_select)
        pcs_pkg::PCS_CO_BUS: general_clock_output_pin_o <= syn[`PCS_IN_BUS];
        pcs_pkg::PCS_CO_LPO: general_clock_output_pin_o <= syn[`PCS_IN_LPO];
        pcs_pkg::PCS_CO_IRC: general_clock_output_pin_o <= syn[`PCS_IN_IRC];
        pcs_pkg::PCS_CO_OSC: general_clock_output_pin_o <= syn[`PCS_IN_OSC];
        default: general_clock_output_pin_o <= 1'b0;
      endcase
      rtc_clock_output_pin_o <= rtc_output_select ? syn[`PCS_IN_OSC]
                                                  : syn[`PCS_IN_RTC];
    end
  end

  // ----------------------------------------------------------------------
  // Timer external clock and capture routing
  // ----------------------------------------------------------------------

  // The pin mux must also be set up by software, otherwise the pin is idle.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      timer0_ext_clock_o <= 1'b0;
      timer1_ext_clock_o <= 1'b0;
      timer2_ext_clock_o <= 1'b0;
    end else begin
      timer2_ext_clock_o <= timer2_ext_clock_pin ? syn[`PCS_IN_PINB]
                                                 : syn[`PCS_IN_PINA];
      timer1_ext_clock_o <= timer1_ext_clock_pin ? syn[`PCS_IN_PINB]
                                                 : syn[`PCS_IN_PINA];
      timer0_ext_clock_o <= timer0_ext_clock_pin ? syn[`PCS_IN_PINB]
                                                 : syn[`PCS_IN_PINA];
    end
  end

  // Capture inputs; software is expected to clear these outside capture mode.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      timer1_capture_o <= 1'b0;
      timer2_capture_o <= 1'b0;
    end else begin
      timer2_capture_o <= timer2_capture_source ? syn[`PCS_IN_CMP]
                                                : syn[`PCS_IN_T2CH];
      timer1_capture_o <= timer1_capture_source ? syn[`PCS_IN_CMP]
                                                : syn[`PCS_IN_T1CH];
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  // A write to an options register followed directly by a read of it.
  sequence cso_wr_rd_s;
    (wr_i && pcs_hit(addr_i, `PCS_CSO_OFF)) ##1 (rd_i && pcs_hit(addr_i, `PCS_CSO_OFF));
  endsequence

  sequence tso_wr_rd_s;
    (wr_i && pcs_hit(addr_i, `PCS_TSO_OFF)) ##1 (rd_i && pcs_hit(addr_i, `PCS_TSO_OFF));
  endsequence

  cso_readback_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cso_wr_rd_s |=> rdata_o == ($past(wdata_i, 2) & `PCS_CSO_MASK))
    else $error("clock options readback mismatch");
  tso_readback_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    tso_wr_rd_s |=> rdata_o == ($past(wdata_i, 2) & `PCS_TSO_MASK))
    else $error("timer options readback mismatch");
  reserved_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_i && pcs_hit(addr_i, `PCS_CSO_OFF)) |=> (rdata_o & ~`PCS_CSO_MASK) == '0)
    else $error("reserved clock option bit read as one");
  rdata_idle_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == '0)
    else $error("read data present without a read");
  ser0_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (serial0_clock_source == 2'h0) [*2] |=> !serial0_clock_o)
    else $error("serial clock runs while disabled");
  tmr_osc_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (timer_counter_clock_source == 2'h2) |=> timer_counter_clock_o == $past(syn[`PCS_IN_OSC]))
    else $error("timer clock not from oscillator");
  usb_pin_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !usb_clock_source |=> usb_clock_o == $past(syn[`PCS_IN_USB]))
    else $error("usb clock not from bypass pin");
  hs_fll_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!highspeed_clock_pick && usb_clock_source) |=> usb_clock_o == $past(syn[`PCS_IN_FLL]))
    else $error("high-speed pick not routing fll");
  general_clock_output_pin_rsv_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clock_output_select[0] && clock_output_select[2]) |=> !general_clock_output_pin_o)
    else $error("reserved clock output code drives pin");
  rtc_out_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    rtc_output_select |=> rtc_clock_output_pin_o == $past(syn[`PCS_IN_OSC]))
    else $error("rtc pin not from oscillator");
  t2_pin_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer2_ext_clock_pin |=> timer2_ext_clock_o == $past(syn[`PCS_IN_PINB]))
    else $error("timer two pin select wrong");
  t0_pin_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !timer0_ext_clock_pin |=> timer0_ext_clock_o == $past(syn[`PCS_IN_PINA]))
    else $error("timer zero pin select wrong");

  t2_cap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer2_capture_source |=> timer2_capture_o == $past(syn[`PCS_IN_CMP]))
    else $error("timer two capture not from comparator");

  t1_cap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !timer1_capture_source |=> timer1_capture_o == $past(syn[`PCS_IN_T1CH]))
    else $error("timer one capture not from pin");

endmodule

`default_nettype wire

// ---- logic/pcs_defines.svh ----
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register bus geometry
// ----------------------------------------------------------------------
`define PCS_ADDR_W 8
`define PCS_DATA_W 32

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define PCS_CSO_OFF 8'h00
`define PCS_TSO_OFF 8'h04

// ----------------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------------
`define PCS_CSO_RST 32'h0000_0000
`define PCS_TSO_RST 32'h0000_0000
`define PCS_CSO_MASK 32'h0F05_00F0
`define PCS_TSO_MASK 32'h0714_0000

// ----------------------------------------------------------------------
// Field positions in the clock source options register
// ----------------------------------------------------------------------
`define PCS_SER0_HI 27
`define PCS_SER0_LO 26
`define PCS_TMR_HI 25
`define PCS_TMR_LO 24
`define PCS_USB_BIT 18
`define PCS_HS_BIT 16
`define PCS_GENERAL_CLOCK_OUTPUT_PIN_HI 7
`define PCS_GENERAL_CLOCK_OUTPUT_PIN_LO 5
`define PCS_RTC_BIT 4

// ----------------------------------------------------------------------
// Field positions in the timer source options register
// ----------------------------------------------------------------------
`define PCS_T2PIN_BIT 26
`define PCS_T1PIN_BIT 25
`define PCS_T0PIN_BIT 24
`define PCS_T2CAP_BIT 20
`define PCS_T1CAP_BIT 18

// ----------------------------------------------------------------------
// Synchroniser geometry and input lane positions
// ----------------------------------------------------------------------
`define PCS_NSYNC 13
`define PCS_IN_FLL 0
`define PCS_IN_PLL 1
`define PCS_IN_OSC 2
`define PCS_IN_IRC 3
`define PCS_IN_USB 4
`define PCS_IN_BUS 5
`define PCS_IN_LPO 6
`define PCS_IN_RTC 7
`define PCS_IN_PINA 8
`define PCS_IN_PINB 9
`define PCS_IN_CMP 10
`define PCS_IN_T2CH 11
`define PCS_IN_T1CH 12

`endif

// ---- logic/pcs_pkg.sv ----
`default_nettype none

package pcs_pkg;

  // Two-bit clock source code shared by the serial and timer selectors.
  typedef enum logic [1:0] {
    PCS_SRC_OFF = 2'h0,
    PCS_SRC_HS = 2'h1,
    PCS_SRC_OSC = 2'h2,
    PCS_SRC_IRC = 2'h3
  } pcs_src_t;

  // Three-bit code for the general clock output pin.
  typedef enum logic [2:0] {
    PCS_CO_BUS = 3'h2,
    PCS_CO_LPO = 3'h3,
    PCS_CO_IRC = 3'h4,
    PCS_CO_OSC = 3'h6
  } pcs_general_clock_output_pin_t;

endpackage

`default_nettype wire

// ---- logic/pcs_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Two-stage synchroniser for a bank of asynchronous levels.
// ----------------------------------------------------------------------
module pcs_sync2 #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // First stage; only the second stage reads it.
  logic [W-1:0] meta_q;

  // Both stages clear on reset so downstream logic sees a known level.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ---- verification/pcs_clock_select_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module pcs_clock_select_tb_top;
  // ----------------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------------
  logic mclk_i = 1'b0; // System clock, 20 ns period.
  logic rst_i = 1'b1; // Synchronous reset, held at start.
  logic [`PCS_ADDR_W-1:0] addr_i = 8'h00; // Register byte address.
  logic [`PCS_DATA_W-1:0] wdata_i = 32'h0000_0000; // Register write data.
  logic wr_i = 1'b0; // Write strobe.
  logic rd_i = 1'b0; // Read strobe.
  wire logic [`PCS_DATA_W-1:0] rdata_o; // Read data, one cycle after the strobe.
  logic [`PCS_NSYNC-1:0] src = 13'h0000; // Source levels, one lane per input.
  wire logic [9:0] outs; // Selected outputs gathered into one vector.
  int fail_count = 0; // Mismatches seen.
  int n_checks = 0; // Comparisons made.

  // The clock toggles every half period.
  always #10 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------------
  // Device under test
  // ----------------------------------------------------------------------
  pcs_clock_select u_pcs_clock_select (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .fll_output_clock_i(src[`PCS_IN_FLL]), .pll_output_clock_i(src[`PCS_IN_PLL]),
    .oscillator_reference_clock_i(src[`PCS_IN_OSC]),
    .internal_reference_clock_i(src[`PCS_IN_IRC]),
    .usb_bypass_clock_pin_i(src[`PCS_IN_USB]), .bus_clock_i(src[`PCS_IN_BUS]),
    .low_power_oscillator_i(src[`PCS_IN_LPO]), .rtc_tick_i(src[`PCS_IN_RTC]),
    .timer_ext_clock_pin_a_i(src[`PCS_IN_PINA]), .timer_ext_clock_pin_b_i(src[`PCS_IN_PINB]),
    .analog_comparator_zero_i(src[`PCS_IN_CMP]),
    .timer2_channel0_pin_i(src[`PCS_IN_T2CH]), .timer1_channel0_pin_i(src[`PCS_IN_T1CH]),
    .serial0_clock_o(outs[0]), .timer_counter_clock_o(outs[1]), .usb_clock_o(outs[2]),
    .general_clock_output_pin_o(outs[3]), .rtc_clock_output_pin_o(outs[4]),
    .timer0_ext_clock_o(outs[5]), .timer1_ext_clock_o(outs[6]),
    .timer2_ext_clock_o(outs[7]), .timer1_capture_o(outs[8]), .timer2_capture_o(outs[9])
  );

  // ----------------------------------------------------------------------
  // Comparison and bus tasks
  // ----------------------------------------------------------------------
  // Compares a register word and counts the outcome.
  task automatic cmp_word(input logic [31:0] act, input logic [31:0] exp);
    n_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  // Compares one output level and counts the outcome.
  task automatic cmp_level(input logic act, input logic exp);
    n_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  // One-cycle write; the strobe drops at the edge that takes it.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // One-cycle read; data is taken in the cycle after the taking edge.
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // Reads a register and compares it with the expected word.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(a, d);
    cmp_word(d, exp);
  endtask

  // Write strobe, then a read strobe of the same word on the very next edge.
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    cmp_word(rdata_o, exp);
  endtask

  // Writes a selection, then drives the chosen lane high with all others
  // low and the reverse, so a wrong lane or a stuck output shows.
  // A lane of -1 means the output must stay low whatever the sources do.
  task automatic path(input logic [7:0] a, input logic [31:0] d, input int o, input int s);
    reg_wr(a, d);
    for (int v = 0; v < 2; v++) begin
      @(posedge mclk_i);
      if (s < 0) begin
        src <= (v == 1) ? 13'h1FFF : 13'h0000;
      end else begin
        src <= (v == 1) ? (13'h0001 << s) : ~(13'h0001 << s);
      end
      repeat (6) @(posedge mclk_i);
      #1;
      cmp_level(outs[o], (s >= 0) && (v == 1));
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset values, unmapped reads, writable masks and the read data pulse.
  task automatic t_regs;
    logic [31:0] d;
    rd_chk(`PCS_CSO_OFF, `PCS_CSO_RST);
    rd_chk(`PCS_TSO_OFF, `PCS_TSO_RST);
    reg_wr(`PCS_CSO_OFF, 32'hFFFF_FFFF);
    rd_chk(`PCS_CSO_OFF, `PCS_CSO_MASK);
    @(posedge mclk_i);
    #1;
    cmp_word(rdata_o, 32'h0000_0000);
    reg_wr(`PCS_TSO_OFF, 32'hFFFF_FFFF);
    reg_wr(8'h08, 32'h0000_0000);
    rd_chk(`PCS_TSO_OFF, `PCS_TSO_MASK);
    rd_chk(`PCS_CSO_OFF, `PCS_CSO_MASK);
    rd_chk(8'h08, 32'h0000_0000);
    reg_wr(`PCS_TSO_OFF, 32'h0500_0000);
    rd_chk(`PCS_TSO_OFF, 32'h0500_0000);
    // Back-to-back strobes: the read must already see the new word.
    wr_rd(`PCS_CSO_OFF, 32'hA5A5_A5A5, 32'h0505_00A0);
    wr_rd(`PCS_TSO_OFF, 32'hA5A5_A5A5, 32'h0504_0000);
    reg_wr(`PCS_CSO_OFF, 32'h0000_0000);
    reg_rd(`PCS_CSO_OFF, d);
    cmp_word(d, 32'h0000_0000);
    $display("test regs done");
  endtask

  // The halved PLL path flips once per PLL rising edge on both selectors.
  task automatic t_pll;
    reg_wr(`PCS_CSO_OFF, 32'h0501_0000);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_i);
      src[`PCS_IN_PLL] <= 1'b1;
      repeat (3) @(posedge mclk_i);
      src[`PCS_IN_PLL] <= 1'b0;
      repeat (4) @(posedge mclk_i);
      #1;
      cmp_level(outs[0], (k % 2) == 0);
      cmp_level(outs[1], (k % 2) == 0);
    end
    $display("test pll done");
  endtask

  // Every code of the serial and timer counter clock source fields.
  task automatic t_src_codes;
    int lane[4];
    lane = '{-1, `PCS_IN_FLL, `PCS_IN_OSC, `PCS_IN_IRC};
    for (int c = 0; c < 4; c++) begin
      path(`PCS_CSO_OFF, 32'(c) << 26, 0, lane[c]);
      path(`PCS_CSO_OFF, 32'(c) << 24, 1, lane[c]);
    end
    $display("test source codes done");
  endtask

  // USB source, every clock output code and the RTC output pick.
  task automatic t_outputs;
    int lane[8];
    lane = '{-1, -1, `PCS_IN_BUS, `PCS_IN_LPO, `PCS_IN_IRC, -1, `PCS_IN_OSC, -1};
    path(`PCS_CSO_OFF, 32'h0000_0000, 2, `PCS_IN_USB);
    path(`PCS_CSO_OFF, 32'h0004_0000, 2, `PCS_IN_FLL);
    for (int c = 0; c < 8; c++) begin
      path(`PCS_CSO_OFF, 32'(c) << 5, 3, lane[c]);
    end
    path(`PCS_CSO_OFF, 32'h0000_0000, 4, `PCS_IN_RTC);
    path(`PCS_CSO_OFF, 32'h0000_0010, 4, `PCS_IN_OSC);
    $display("test outputs done");
  endtask

  // Timer external clock pins and channel zero capture sources.
  task automatic t_timers;
    // The bench drives the timer pins directly, standing in for a set-up pin mux.
    for (int i = 0; i < 3; i++) begin
      path(`PCS_TSO_OFF, 32'h0000_0000, 5 + i, `PCS_IN_PINA);
      path(`PCS_TSO_OFF, 32'h0100_0000 << i, 5 + i, `PCS_IN_PINB);
    end
    path(`PCS_TSO_OFF, 32'h0000_0000, 8, `PCS_IN_T1CH);
    path(`PCS_TSO_OFF, 32'h0004_0000, 8, `PCS_IN_CMP);
    path(`PCS_TSO_OFF, 32'h0000_0000, 9, `PCS_IN_T2CH);
    path(`PCS_TSO_OFF, 32'h0010_0000, 9, `PCS_IN_CMP);
    // Capture work is over, so software clears both capture source bits.
    reg_wr(`PCS_TSO_OFF, 32'h0000_0000);
    rd_chk(`PCS_TSO_OFF, 32'h0000_0000);
    $display("test timers done");
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs();
    t_pll();
    t_src_codes();
    t_outputs();
    t_timers();
    summarize();
  end

  // Watchdog: a run that outlives its bound counts as a mismatch.
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    summarize();
  end
endmodule

`default_nettype wire
